// ---- design/sram_ctrl_cfg.svh ----
`ifndef SRAM_CTRL_CFG_SVH
`define SRAM_CTRL_CFG_SVH

// geometry of the attached static ram
`define SRAM_DEPTH 32768
`define SRAM_ADDR_W 15
`define SRAM_DATA_W 8
`define TIMER_W 8

// pin levels, all strobes are active low
`define STROBE_ON 1'b0
`define STROBE_OFF 1'b1
`define FLAG_SET 1'b1
`define FLAG_CLR 1'b0

// reference clock
`define CLK_PERIOD_NS 50

// slowest grade figures, ns; they are safe for every faster grade too
`define READ_CYCLE_TIME_NS 35
`define ADDRESS_ACCESS_TIME_NS 35
`define SELECT_ACCESS_TIME_NS 35
`define OUTEN_ACCESS_TIME_NS 15
`define OUTPUT_HOLD_TIME_NS 3
`define SELECT_TO_DRIVE_TIME_NS 3
`define OUTEN_TO_DRIVE_TIME_NS 0
`define DESELECT_TO_FLOAT_TIME_NS 15
`define OUTDIS_TO_FLOAT_TIME_NS 15
`define WRITE_CYCLE_TIME_NS 35
`define SELECT_TO_WRITE_END_NS 30
`define ADDRESS_TO_WRITE_END_NS 30
`define ADDRESS_SETUP_TIME_NS 0
`define WRITE_PULSE_TIME_NS 20
`define WRITE_RECOVERY_TIME_NS 0
`define WRITE_TO_FLOAT_TIME_NS 15
`define DATA_SETUP_TO_WRITE_END_NS 15
`define DATA_HOLD_AFTER_WRITE_NS 0
`define DESELECT_TO_RETENTION_TIME_NS 0
`define RETENTION_RECOVERY_TIME_NS `READ_CYCLE_TIME_NS

// conversions: a least time rounds up, never below one cycle
`define MAX2(a, b) (((a) > (b)) ? (a) : (b))
`define AT_LEAST_ONE(x) `MAX2((x), 1)
`define CYC_MIN(t) `AT_LEAST_ONE(((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// cycle counts used by the sequencer
`define READ_WAIT_CYC `CYC_MIN(`MAX2(`MAX2(`ADDRESS_ACCESS_TIME_NS, `SELECT_ACCESS_TIME_NS), \
  `MAX2(`OUTEN_ACCESS_TIME_NS, `READ_CYCLE_TIME_NS)))
`define READ_FLOAT_CYC `CYC_MIN(`MAX2(`DESELECT_TO_FLOAT_TIME_NS, `OUTDIS_TO_FLOAT_TIME_NS))
`define WRITE_SETUP_CYC `CYC_MIN(`MAX2(`ADDRESS_SETUP_TIME_NS, `WRITE_TO_FLOAT_TIME_NS))
`define WRITE_PULSE_CYC `CYC_MIN(`MAX2(`MAX2(`SELECT_TO_WRITE_END_NS, `ADDRESS_TO_WRITE_END_NS), \
  `MAX2(`WRITE_PULSE_TIME_NS, `DATA_SETUP_TO_WRITE_END_NS)))
`define WRITE_HOLD_CYC `CYC_MIN(`MAX2(`DATA_HOLD_AFTER_WRITE_NS, `WRITE_RECOVERY_TIME_NS))
`define WRITE_CYCLE_CYC `CYC_MIN(`WRITE_CYCLE_TIME_NS)
`define RETAIN_LEAD_CYC `CYC_MIN(`DESELECT_TO_RETENTION_TIME_NS)
`define RETAIN_RECOVER_CYC `CYC_MIN(`RETENTION_RECOVERY_TIME_NS)

`endif

// ---- design/sram_ctrl_pkg.sv ----
`include "sram_ctrl_cfg.svh"

package sram_ctrl_pkg;

  typedef logic [`SRAM_ADDR_W-1:0] sram_addr_t;
  typedef logic [`SRAM_DATA_W-1:0] sram_data_t;
  typedef logic [`TIMER_W-1:0] tick_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACCESS,
    ST_RD_FLOAT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RETAIN,
    ST_RECOVER
  } ctrl_state_t;

  typedef struct packed {
    ctrl_state_t st;
    sram_addr_t addr;
    sram_data_t dq_out;
    logic dq_oe_n;
    logic cs_n;
    logic we_n;
    logic oe_n;
    sram_data_t rdata;
    logic rvalid;
    logic wdone;
    logic ready;
    logic retention;
  } ctrl_regs_t;

  typedef struct packed {
    tick_t cnt;
  } timer_regs_t;

endpackage

// ---- design/timer_if.sv ----
`timescale 1ns/10ps
`include "sram_ctrl_cfg.svh"

interface timer_if;
  logic load;
  logic [`TIMER_W-1:0] count;
  logic done;

  // the sequencer loads a count, the timer reports when it has run out
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// ---- design/sram_pin_timer.sv ----
`timescale 1ns/10ps

module sram_pin_timer
  import sram_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  timer_if.timer tmr
);

  timer_regs_t q, d;

  // a load of n-1 makes done high in the nth cycle of the new state
  always_comb begin
    d = q;
    if (tmr.load) begin
      d.cnt = tmr.count;
    end else if (q.cnt != tick_t'(0)) begin
      d.cnt = q.cnt - tick_t'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // done is taken from the register so it never depends on this cycle's load
  assign tmr.done = (q.cnt == tick_t'(0));

endmodule

// ---- design/sram_ctrl.sv ----
// Overview of operation
// [RULE_01] ram holds 32768 bytes, one shared port
// [RULE_02] read: write strobe high, output strobe low
// [RULE_03] read waits worst access and cycle time
// [RULE_04] data valid within select access time
// [RULE_05] data valid within output enable access
// [RULE_06] old data held briefly after address change
// [RULE_07] ram drives only after select and enable
// [RULE_08] ram floats within deselect or disable time
// [RULE_09] write only while select and write low
// [RULE_10] select held long enough before write end
// [RULE_11] address valid long enough before write end
// [RULE_12] write ends at first rising strobe
// [RULE_13] write data set up before write end
// [RULE_14] write data may drop at write end
// [RULE_15] ram floats after write strobe falls
// [RULE_16] ram resumes driving shortly after write
// [RULE_17] late select keeps ram pins floating
// [RULE_18] never drive pins while ram drives them
// [RULE_19] write strobe high on every address change
// [RULE_20] enabled outputs echo written data afterwards
// [RULE_21] deselect before retention, wait after recovery
// [RULE_22] ram floats when deselected or disabled
`timescale 1ns/10ps
`include "sram_ctrl_cfg.svh"

module sram_ctrl
  import sram_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // user side
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [`SRAM_ADDR_W-1:0] i_addr,
  input wire logic [`SRAM_DATA_W-1:0] i_wdata,
  input wire logic i_retain,
  output logic o_ready,
  output logic [`SRAM_DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic o_wdone,
  output logic o_retention,
  // ram pins
  output logic [`SRAM_ADDR_W-1:0] o_sram_addr,
  output logic o_sram_cs_n,
  output logic o_sram_we_n,
  output logic o_sram_oe_n,
  output logic [`SRAM_DATA_W-1:0] o_sram_dq,
  output logic o_sram_dq_oe_n,
  input wire logic [`SRAM_DATA_W-1:0] i_sram_dq
);

  // reset image: everything deselected, data pins released, ready for work
  localparam ctrl_regs_t CTRL_RESET = '{
    st: ST_IDLE,
    addr: '0,
    dq_out: '0,
    dq_oe_n: `STROBE_OFF,
    cs_n: `STROBE_OFF,
    we_n: `STROBE_OFF,
    oe_n: `STROBE_OFF,
    rdata: '0,
    rvalid: `FLAG_CLR,
    wdone: `FLAG_CLR,
    ready: `FLAG_SET,
    retention: `FLAG_CLR
  };

  // loads are n-1 so that the state lasts exactly n cycles
  localparam tick_t READ_WAIT_LOAD = tick_t'(`READ_WAIT_CYC - 1);
  localparam tick_t READ_FLOAT_LOAD = tick_t'(`READ_FLOAT_CYC - 1);
  localparam tick_t WRITE_SETUP_LOAD = tick_t'(`WRITE_SETUP_CYC - 1);
  localparam tick_t WRITE_HOLD_LOAD = tick_t'(`WRITE_HOLD_CYC - 1);
  localparam tick_t RETAIN_RECOVER_LOAD = tick_t'(`RETAIN_RECOVER_CYC - 1);
  localparam tick_t RETAIN_LEAD_LOAD = tick_t'(`RETAIN_LEAD_CYC - 1);

  // the pulse is stretched so that setup, pulse and hold still fill a write cycle
  localparam int WRITE_PULSE_FILL = `WRITE_CYCLE_CYC - `WRITE_SETUP_CYC - `WRITE_HOLD_CYC;
  localparam tick_t WRITE_PULSE_LOAD = tick_t'(`MAX2(`WRITE_PULSE_CYC, WRITE_PULSE_FILL) - 1);

  ctrl_regs_t q, d;

  timer_if tmr ();

  sram_pin_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .tmr(tmr)
  );

  // timer handshake, driven from the sequencer below
  logic tmr_load;
  tick_t tmr_count;

  assign tmr.load = tmr_load;
  assign tmr.count = tmr_count;

  // sequencer: every pin level is decided here and registered once
  always_comb begin
    d = q;
    d.rvalid = `FLAG_CLR;
    d.wdone = `FLAG_CLR;
    tmr_load = 1'b0;
    tmr_count = '0;
    case (q.st)
      ST_IDLE: begin
        if (i_retain) begin
          // retention wins over a request: the ram is already deselected here
          d.cs_n = `STROBE_OFF; // RULE_21
          d.st = ST_RETAIN;
          d.ready = `FLAG_CLR;
          tmr_load = 1'b1;
          tmr_count = RETAIN_LEAD_LOAD;
        end else if (i_req) begin
          // address moves only here, with the write strobe high
          d.addr = i_addr; // RULE_19
          d.we_n = `STROBE_OFF; // RULE_19
          d.cs_n = `STROBE_ON;
          d.ready = `FLAG_CLR;
          tmr_load = 1'b1;
          if (i_write) begin
            // output enable stays high, so the ram never drives during a write
            d.oe_n = `STROBE_OFF; // RULE_18
            d.dq_out = i_wdata;
            d.st = ST_WR_SETUP;
            tmr_count = WRITE_SETUP_LOAD;
          end else begin
            // read: write strobe high, select and output enable low together
            d.oe_n = `STROBE_ON; // RULE_02
            d.st = ST_RD_ACCESS;
            tmr_count = READ_WAIT_LOAD; // RULE_03
          end
        end
      end
      ST_RD_ACCESS: begin
        // worst of address, select and enable access have passed when done
        if (tmr.done) begin
          // sample before the address or strobes move, old data still valid
          d.rdata = i_sram_dq; // RULE_04 RULE_05 RULE_06
          d.rvalid = `FLAG_SET;
          d.cs_n = `STROBE_OFF;
          d.oe_n = `STROBE_OFF;
          d.st = ST_RD_FLOAT;
          tmr_load = 1'b1;
          tmr_count = READ_FLOAT_LOAD; // RULE_08
        end
      end
      ST_RD_FLOAT: begin
        // no drive of our own until the ram has surely released the pins
        if (tmr.done) begin
          d.ready = `FLAG_SET; // RULE_08 RULE_22
          d.st = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        // address and select settle with the write strobe still high
        if (tmr.done) begin
          d.we_n = `STROBE_ON; // RULE_09 RULE_11
          d.dq_oe_n = `STROBE_ON; // RULE_17 RULE_18
          d.st = ST_WR_PULSE;
          tmr_load = 1'b1;
          tmr_count = WRITE_PULSE_LOAD; // RULE_09 RULE_10 RULE_13
        end
      end
      ST_WR_PULSE: begin
        // both strobes rise on one edge, which ends the write
        if (tmr.done) begin
          d.we_n = `STROBE_OFF; // RULE_12
          d.cs_n = `STROBE_OFF; // RULE_12
          d.st = ST_WR_END;
          tmr_load = 1'b1;
          tmr_count = WRITE_HOLD_LOAD; // RULE_14
        end
      end
      ST_WR_END: begin
        // data is kept a full cycle past the write end, more than zero hold
        if (tmr.done) begin
          d.dq_oe_n = `STROBE_OFF; // RULE_14
          d.wdone = `FLAG_SET;
          d.ready = `FLAG_SET;
          d.st = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        // select stays high for the whole time the supply may be lowered
        if (!i_retain && tmr.done) begin
          d.retention = `FLAG_CLR;
          d.st = ST_RECOVER;
          tmr_load = 1'b1;
          tmr_count = RETAIN_RECOVER_LOAD; // RULE_21
        end else if (tmr.done) begin
          d.retention = `FLAG_SET; // RULE_21
        end
      end
      ST_RECOVER: begin
        // one read cycle of quiet after the supply is back
        if (tmr.done) begin
          d.ready = `FLAG_SET; // RULE_21
          d.st = ST_IDLE;
        end
      end
      default: begin
        d = CTRL_RESET;
      end
    endcase
  end

  // single state register; every output below comes straight from it
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // address width and data width match the 32k by 8 part
  assign o_sram_addr = q.addr; // RULE_01
  assign o_sram_cs_n = q.cs_n;
  assign o_sram_we_n = q.we_n;
  assign o_sram_oe_n = q.oe_n;
  assign o_sram_dq = q.dq_out;
  assign o_sram_dq_oe_n = q.dq_oe_n; // RULE_01
  assign o_ready = q.ready;
  assign o_rdata = q.rdata;
  assign o_rvalid = q.rvalid;
  assign o_wdone = q.wdone;
  assign o_retention = q.retention;

endmodule

// ---- bench/sram_model.sv ----
`timescale 1ns/10ps
`include "sram_ctrl_cfg.svh"
module sram_model
  import sram_ctrl_pkg::*;
(
  input wire logic [`SRAM_ADDR_W-1:0] i_addr,
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [`SRAM_DATA_W-1:0] i_dq,
  output logic [`SRAM_DATA_W-1:0] o_dq,
  output logic o_drive
);
  sram_data_t mem [`SRAM_DEPTH];
  sram_data_t last = '0;
  sram_data_t wbuf;
  logic wr_on = 1'b0;
  // a write is the overlap of select and strobe; it lands when either rises
  always @(i_cs_n, i_we_n, i_dq) begin
    if (!i_cs_n && !i_we_n) begin
      wr_on = 1'b1;
      wbuf = i_dq;
    end else if (wr_on) begin
      mem[i_addr] = wbuf;
      wr_on = 1'b0;
    end
  end
  // drive only for a read; a released line shows the inverse, never a stale copy
  always @* begin
    o_drive = !i_cs_n && !i_oe_n && i_we_n;
    if (o_drive) last = mem[i_addr];
    o_dq = o_drive ? last : ~last;
  end
endmodule

// ---- bench/sram_ctrl_sva.sv ----
`timescale 1ns/10ps
`include "sram_ctrl_cfg.svh"
module sram_ctrl_sva
  import sram_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [`SRAM_DATA_W-1:0] i_sram_dq,
  input wire logic o_ready,
  input wire logic [`SRAM_DATA_W-1:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_wdone,
  input wire logic o_retention,
  input wire logic [`SRAM_ADDR_W-1:0] o_sram_addr,
  input wire logic o_sram_cs_n,
  input wire logic o_sram_we_n,
  input wire logic o_sram_oe_n,
  input wire logic [`SRAM_DATA_W-1:0] o_sram_dq,
  input wire logic o_sram_dq_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  chk_read_strobes: assert property (!o_sram_oe_n |-> o_sram_we_n && !o_sram_cs_n)
    else $error("read strobes mixed");
  chk_read_result: assert property ($rose(o_rvalid) |-> !$past(o_sram_oe_n) && o_rdata == $past(i_sram_dq))
    else $error("read data not from ram");
  chk_read_span: assert property ($fell(o_sram_oe_n) |-> ##1 (o_rvalid && o_sram_cs_n) ##1 o_ready)
    else $error("read span wrong");
  chk_write_pulse: assert property ($fell(o_sram_we_n) |-> !$past(o_sram_cs_n) ##1 (o_sram_we_n && o_sram_cs_n))
    else $error("write pulse wrong");
  chk_data_setup: assert property (!o_sram_we_n |-> !o_sram_dq_oe_n && $stable(o_sram_dq))
    else $error("write data not set up");
  chk_data_hold: assert property ($rose(o_sram_we_n) |-> !o_sram_dq_oe_n ##1 (o_sram_dq_oe_n && o_wdone))
    else $error("write end wrong");
  chk_no_clash: assert property (!o_sram_dq_oe_n |-> o_sram_oe_n)
    else $error("pins driven during read");
  chk_addr_quiet: assert property (!$stable(o_sram_addr) |-> o_sram_we_n && $past(o_sram_we_n))
    else $error("address moved in write");
  chk_retain_off: assert property (o_retention |-> o_sram_cs_n && !o_ready)
    else $error("selected in retention");
  chk_idle_float: assert property (o_ready |-> o_sram_cs_n && o_sram_dq_oe_n)
    else $error("pins active when idle");
  cover property ($rose(o_rvalid));
  cover property ($rose(o_wdone));
  cover property ($rose(o_retention));
endmodule
bind sram_ctrl sram_ctrl_sva chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sram_dq(i_sram_dq),
  .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_wdone(o_wdone), .o_retention(o_retention),
  .o_sram_addr(o_sram_addr), .o_sram_cs_n(o_sram_cs_n), .o_sram_we_n(o_sram_we_n), .o_sram_oe_n(o_sram_oe_n),
  .o_sram_dq(o_sram_dq), .o_sram_dq_oe_n(o_sram_dq_oe_n));

// ---- bench/tb.sv ----
`timescale 1ns/10ps
`include "sram_ctrl_cfg.svh"
module tb
  import sram_ctrl_pkg::*;
;
  logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_req = 1'b0, i_write = 1'b0, i_retain = 1'b0;
  sram_addr_t i_addr = '0, o_sram_addr;
  sram_data_t i_wdata = '0, o_rdata, o_sram_dq, i_sram_dq, ram_q;
  logic o_ready, o_rvalid, o_wdone, o_retention, o_sram_cs_n, o_sram_we_n, o_sram_oe_n, o_sram_dq_oe_n, ram_drv;
  int fails = 0, n_tests = 0, cyc = 0;
  sram_ctrl uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_write(i_write), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_retain(i_retain), .o_ready(o_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_wdone(o_wdone), .o_retention(o_retention), .o_sram_addr(o_sram_addr), .o_sram_cs_n(o_sram_cs_n),
    .o_sram_we_n(o_sram_we_n), .o_sram_oe_n(o_sram_oe_n), .o_sram_dq(o_sram_dq), .o_sram_dq_oe_n(o_sram_dq_oe_n),
    .i_sram_dq(i_sram_dq));
  sram_model ram (.i_addr(o_sram_addr), .i_cs_n(o_sram_cs_n), .i_we_n(o_sram_we_n), .i_oe_n(o_sram_oe_n),
    .i_dq(i_sram_dq), .o_dq(ram_q), .o_drive(ram_drv));
  // the shared wire: controller wins only while its enable is low
  assign i_sram_dq = o_sram_dq_oe_n ? ram_q : o_sram_dq;
  initial begin
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // inputs move 1 ns after the edge so the design never races the bench
  task automatic step;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wait_rdy;
    for (int k = 0; k < 20 && o_ready !== 1'b1; k++) step;
    chk("ready", 16'(o_ready), 16'h0001);
  endtask
  task automatic take(input logic w, input sram_addr_t a, input sram_data_t d);
    wait_rdy;
    i_req = 1'b1;
    i_write = w;
    i_addr = a;
    i_wdata = d;
    step;
    i_req = 1'b0;
  endtask
  task automatic do_write(input sram_addr_t a, input sram_data_t d);
    take(1'b1, a, d);
    chk("addr", 16'(o_sram_addr), 16'(a));
    step;
    chk("we_n", 16'(o_sram_we_n), 16'h0000);
    chk("dq", 16'(o_sram_dq), 16'(d));
    step;
    step;
    chk("wdone", 16'(o_wdone), 16'h0001);
  endtask
  task automatic do_read(input sram_addr_t a, input sram_data_t e);
    take(1'b0, a, '0);
    chk("oe_n", 16'(o_sram_oe_n), 16'h0000);
    step;
    chk("rvalid", 16'(o_rvalid), 16'h0001);
    chk("rdata", 16'(o_rdata), 16'(e));
    step;
    chk("rvalid drop", 16'(o_rvalid), 16'h0000);
  endtask
  task automatic t_reset;
    chk("idle pins", 16'({o_sram_cs_n, o_sram_we_n, o_sram_oe_n, o_sram_dq_oe_n}), 16'h000f);
    chk("idle rdata", 16'(o_rdata), 16'h0000);
    chk("idle flags", 16'({o_ready, o_rvalid, o_wdone, o_retention}), 16'h0008);
  endtask
  // lowest, highest and middle byte of the array
  task automatic t_corners;
    sram_addr_t ad [3] = '{15'h0000, 15'h7fff, 15'h4000};
    sram_data_t dv [3] = '{8'h00, 8'h5a, 8'ha5};
    for (int i = 0; i < 3; i++) do_write(ad[i], dv[i]);
    for (int i = 0; i < 3; i++) do_read(ad[i], dv[i]);
  endtask
  // overwrite and read straight away, no idle gap
  task automatic t_b2b;
    do_write(15'h1234, 8'h3c);
    do_read(15'h1234, 8'h3c);
    do_write(15'h1234, 8'hc3);
    do_read(15'h1234, 8'hc3);
    do_read(15'h7fff, 8'h5a);
  endtask
  task automatic t_retain;
    wait_rdy;
    // a request in the same cycle must lose to retention
    i_retain = 1'b1;
    i_req = 1'b1;
    i_write = 1'b0;
    i_addr = 15'h0001;
    step;
    i_req = 1'b0;
    chk("retain wins", 16'({o_sram_cs_n, o_ready}), 16'h0002);
    step;
    step;
    chk("retention", 16'(o_retention), 16'h0001);
    chk("cs_n", 16'(o_sram_cs_n), 16'h0001);
    i_retain = 1'b0;
    step;
    step;
    chk("retention off", 16'(o_retention), 16'h0000);
    do_read(15'h4000, 8'ha5);
  endtask
  always @(negedge i_ref_clk) begin
    if (i_reset_n) chk("clash", 16'(ram_drv && !o_sram_dq_oe_n), 16'h0000);
  end
  // hang guard, well above the roughly fifty cycles the tests use
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize;
    end
  end
  initial begin
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_reset_n = 1'b1;
    t_reset;
    t_corners;
    t_b2b;
    t_retain;
    summarize;
  end
endmodule
